// [verilog/ssc_regs.vh]
// Register offsets, field positions, reset values and timing counts for the sleep controller.
// Assumes a 100 MHz mclk; included by bare name.
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_OFF_SLEEP_EN      8'h10
`define SSC_OFF_CLK_NEED      8'h14
`define SSC_OFF_SLEEP_CTRL    8'h18
`define SSC_OFF_SLEEP_STATE   8'h1C
`define SSC_NEED_MASK         32'h000AEC0F
`define SSC_EN_MASK           32'h001FFC0F
`define SSC_EN_ALL            32'h000AEC0F
`define SSC_EN_RESET          32'h00000000
`define SSC_CTRL_RESET        7'h00
`define SSC_BIT_OSC_PD        0
`define SSC_BIT_OSC_GATE      1
`define SSC_BIT_REG_STBY      2
`define SSC_BIT_SLEEP_ALL     4
`define SSC_BIT_SLEEP_DBG     5
`define SSC_BIT_AUTO_CLR      6
`define SSC_CLK_MHZ           100
`define SSC_SLOW_WAKE_US      600
`define SSC_FAST_WAKE_US      10
`define SSC_SLOW_WAKE_CYC     (`SSC_SLOW_WAKE_US * `SSC_CLK_MHZ)
`define SSC_FAST_WAKE_CYC     (`SSC_FAST_WAKE_US * `SSC_CLK_MHZ - 4)
`define SSC_ST_HEAVY1         3'h0
`define SSC_ST_HEAVY2         3'h1
`define SSC_ST_HEAVY3         3'h2
`define SSC_ST_DEEPEST        3'h3
`define SSC_ST_AWAKE          3'h7
`endif

// [verilog/ssc_wake_timer.v]
// Wake-latency counter: loads a cycle count and pulses done when it runs out.
// Assumes one mclk domain; start is a one-cycle pulse.
`timescale 1ns/1ns
module ssc_wake_timer (
	input  wire        mclk,
	input  wire        resetn,
	input  wire        start,
	input  wire [16:0] load_val,
	output reg         busy_ff,
	output reg         done_ff
);
	reg [16:0] cnt_ff;

	always @(posedge mclk) begin
		if (!resetn) begin
			cnt_ff  <= 17'h00000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				cnt_ff  <= load_val;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				if (cnt_ff == 17'h00000) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 17'h00001;
				end
			end
		end
	end
endmodule // ssc_wake_timer

// [verilog/ssc_sleep_ctrl.v]
// Chip-level sleep controller with Avalon-MM register slave.
// Assumes peripherals drive clock-need levels synchronous to mclk.
`timescale 1ns/1ns
`include "ssc_regs.vh"
module ssc_sleep_ctrl (
	input  wire        mclk,
	input  wire        resetn,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg  [1:0]  avs_response,
	input  wire [31:0] blk_clk_need,
	input  wire        cpu_sleeping,
	input  wire        cpu_int_vector,
	input  wire        wake_slow,
	input  wire        wake_fast,
	output reg  [31:0] blk_sleep_cmd_ff,
	output reg         sys_asleep_ff,
	output reg         reg_standby_ff,
	output reg         osc_gate_ff,
	output reg         osc_pwr_down_ff,
	output reg         clk_valid_ff,
	output reg         hold_cpu_asleep_ff,
	output reg  [2:0]  sleep_state_ff
);
	localparam [2:0] ST_RUN   = 3'b001;
	localparam [2:0] ST_SLEEP = 3'b010;
	localparam [2:0] ST_WAKE  = 3'b100;
	// Full-width copies so the timer load is cut on purpose
	localparam [31:0] SLOW_LOAD_W = `SSC_SLOW_WAKE_CYC;
	localparam [31:0] FAST_LOAD_W = `SSC_FAST_WAKE_CYC;

	reg  [31:0] sleep_en_ff;
	reg  [6:0]  ctrl_ff;
	reg  [2:0]  fsm_ff;
	reg  [2:0]  nxt_fsm;
	reg         ack_ff;
	reg  [31:0] nxt_rdata;
	reg         tmr_start;
	reg  [16:0] tmr_load;
	wire        tmr_busy;
	wire        tmr_done;
	wire        bus_req;
	wire        wr_en;
	wire        all_cmd;
	wire        no_need;
	wire [31:0] need_live;
	wire [31:0] be_mask;
	wire        wr_sleep_en;
	wire        wr_ctrl;
	wire        clr_auto;
	wire        go_sleep;
	wire        go_wake;
	reg  [31:0] nxt_sleep_en;
	reg  [6:0]  nxt_ctrl;
	reg  [31:0] nxt_cmd;
	reg  [2:0]  nxt_state;

	// Byte lane mask from Avalon byteenable
	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	// Encoding of the three power bits into a sleep state
	function [2:0] decode_state;
		input [2:0] bits;
		begin
			case (bits)
			3'b000,
			3'b100:  decode_state = `SSC_ST_HEAVY1;
			3'b010,
			3'b110:  decode_state = `SSC_ST_HEAVY2;
			3'b001,
			3'b011:  decode_state = `SSC_ST_HEAVY3;
			3'b101,
			3'b111:  decode_state = `SSC_ST_DEEPEST;
			default: decode_state = `SSC_ST_HEAVY1;
			endcase
		end
	endfunction

	// Only the four words of the block answer OK
	function is_mapped;
		input [7:0] addr;
		begin
			case (addr)
			`SSC_OFF_SLEEP_EN,
			`SSC_OFF_CLK_NEED,
			`SSC_OFF_SLEEP_CTRL,
			`SSC_OFF_SLEEP_STATE: is_mapped = 1'b1;
			default:              is_mapped = 1'b0;
			endcase
		end
	endfunction

	assign bus_req   = (avs_read | avs_write) & ~ack_ff;
	// Writes land in the answer cycle, the edge at which the master sees it
	assign wr_en       = avs_write & ack_ff;
	assign wr_sleep_en = wr_en & (avs_address == `SSC_OFF_SLEEP_EN);
	assign wr_ctrl     = wr_en & (avs_address == `SSC_OFF_SLEEP_CTRL) & avs_byteenable[0];
	assign clr_auto    = cpu_int_vector & ctrl_ff[`SSC_BIT_AUTO_CLR];
	assign go_sleep    = cpu_sleeping & all_cmd & no_need;
	assign go_wake     = wake_fast | wake_slow | ~all_cmd | ~cpu_sleeping;
	assign be_mask   = lane_mask(avs_byteenable);
	assign need_live = blk_clk_need & `SSC_NEED_MASK;
	assign all_cmd   = ((sleep_en_ff & `SSC_EN_ALL) == `SSC_EN_ALL)
			| ctrl_ff[`SSC_BIT_SLEEP_ALL];
	assign no_need   = (need_live == 32'h00000000);

	// Read mux; status is sampled live in the cycle before the answer
	always @* begin
		case (avs_address)
		`SSC_OFF_SLEEP_EN:    nxt_rdata = sleep_en_ff;
		`SSC_OFF_CLK_NEED:    nxt_rdata = need_live;
		`SSC_OFF_SLEEP_CTRL:  nxt_rdata = {25'h0000000, ctrl_ff};
		`SSC_OFF_SLEEP_STATE: nxt_rdata = {28'h0000000, sys_asleep_ff, sleep_state_ff};
		default:              nxt_rdata = 32'h00000000;
		endcase
	end

	// One wait cycle per access, then a single answer cycle
	always @(posedge mclk) begin
		if (!resetn) begin
			ack_ff          <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			avs_response    <= 2'h0;
		end else begin
			ack_ff          <= bus_req;
			avs_waitrequest <= ~bus_req;
			if (bus_req) begin
				if (avs_read && is_mapped(avs_address))
					avs_readdata <= nxt_rdata;
				else
					avs_readdata <= 32'h00000000;
				if (is_mapped(avs_address))
					avs_response <= 2'h0;
				else
					avs_response <= 2'h3;
			end
		end
	end

	// Hardware clear comes after the write so it wins a same-cycle tie
	always @* begin
		nxt_sleep_en = sleep_en_ff;
		nxt_ctrl     = ctrl_ff;
		if (wr_sleep_en)
			nxt_sleep_en = (sleep_en_ff & ~be_mask)
				| (avs_writedata & be_mask & `SSC_EN_MASK);
		if (wr_ctrl)
			nxt_ctrl = avs_writedata[6:0] & 7'h77;
		if (clr_auto) begin
			nxt_ctrl[`SSC_BIT_SLEEP_ALL] = 1'b0;
			nxt_ctrl[`SSC_BIT_SLEEP_DBG] = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (!resetn) begin
			sleep_en_ff <= `SSC_EN_RESET;
			ctrl_ff     <= `SSC_CTRL_RESET;
		end else begin
			sleep_en_ff <= nxt_sleep_en;
			ctrl_ff     <= nxt_ctrl;
		end
	end

	// Sleep sequencer
	always @* begin
		nxt_fsm   = fsm_ff;
		tmr_start = 1'b0;
		tmr_load  = 17'h00000;
		case (fsm_ff)
		ST_RUN: begin
			if (go_sleep)
				nxt_fsm = ST_SLEEP;
		end
		ST_SLEEP: begin
			if (go_wake) begin
				if (ctrl_ff[`SSC_BIT_OSC_PD]) begin
					tmr_start = 1'b1;
					if (wake_fast)
						tmr_load = FAST_LOAD_W[16:0];
					else
						tmr_load = SLOW_LOAD_W[16:0];
					nxt_fsm   = ST_WAKE;
				end else begin
					nxt_fsm   = ST_RUN;
				end
			end
		end
		// An idle timer here can only mean the count is over; never hang
		ST_WAKE: begin
			if (tmr_done || !tmr_busy)
				nxt_fsm = ST_RUN;
		end
		default: nxt_fsm = ST_RUN;
		endcase
	end

	// Commands and state code settle here; the flops below only copy them
	always @* begin
		if (ctrl_ff[`SSC_BIT_SLEEP_ALL])
			nxt_cmd = `SSC_EN_MASK;
		else
			nxt_cmd = sleep_en_ff & `SSC_EN_MASK;
		if (nxt_fsm == ST_SLEEP)
			nxt_state = decode_state(ctrl_ff[2:0]);
		else
			nxt_state = `SSC_ST_AWAKE;
	end

	always @(posedge mclk) begin
		if (!resetn) begin
			fsm_ff             <= ST_RUN;
			blk_sleep_cmd_ff   <= 32'h00000000;
			hold_cpu_asleep_ff <= 1'b0;
			sleep_state_ff     <= `SSC_ST_AWAKE;
		end else begin
			fsm_ff             <= nxt_fsm;
			blk_sleep_cmd_ff   <= nxt_cmd;
			hold_cpu_asleep_ff <= ctrl_ff[`SSC_BIT_SLEEP_DBG];
			sleep_state_ff     <= nxt_state;
		end
	end

	// Power controls assert only while the sequencer sits asleep; clk_valid_ff asserts only while it sits in run
	always @(posedge mclk) begin
		if (!resetn) begin
			sys_asleep_ff   <= 1'b0;
			reg_standby_ff  <= 1'b0;
			osc_gate_ff     <= 1'b0;
			osc_pwr_down_ff <= 1'b0;
			clk_valid_ff    <= 1'b1;
		end else begin
			sys_asleep_ff   <= (nxt_fsm == ST_SLEEP);
			reg_standby_ff  <= (nxt_fsm == ST_SLEEP)
				& ctrl_ff[`SSC_BIT_REG_STBY] & ctrl_ff[`SSC_BIT_OSC_PD];
			osc_gate_ff     <= (nxt_fsm == ST_SLEEP) & ctrl_ff[`SSC_BIT_OSC_GATE]
				& ~ctrl_ff[`SSC_BIT_OSC_PD];
			osc_pwr_down_ff <= (nxt_fsm == ST_SLEEP) & ctrl_ff[`SSC_BIT_OSC_PD];
			clk_valid_ff    <= (nxt_fsm == ST_RUN);
		end
	end

	// Relock delay only runs after an oscillator power-down
	ssc_wake_timer u_wake_timer (
		.mclk     (mclk),
		.resetn   (resetn),
		.start    (tmr_start),
		.load_val (tmr_load),
		.busy_ff  (tmr_busy),
		.done_ff  (tmr_done)
	);
endmodule // ssc_sleep_ctrl

// [tb/ssc_assertions.sv]
// Port checker for the sleep controller.
// Bound to every ssc_sleep_ctrl; one mclk domain.
`timescale 1ns/1ns
`include "ssc_regs.vh"
module ssc_chk (
	input wire		mclk,
	input wire		resetn,
	input wire [7:0]	avs_address,
	input wire		avs_read,
	input wire		avs_write,
	input wire [31:0]	avs_readdata,
	input wire		avs_waitrequest,
	input wire [1:0]	avs_response,
	input wire [31:0]	blk_clk_need,
	input wire		cpu_sleeping,
	input wire		wake_fast,
	input wire [31:0]	blk_sleep_cmd_ff,
	input wire		sys_asleep_ff,
	input wire		reg_standby_ff,
	input wire		osc_gate_ff,
	input wire		osc_pwr_down_ff,
	input wire		clk_valid_ff,
	input wire [2:0]	sleep_state_ff
);
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
wire req = avs_read | avs_write;
// Relock must not be skipped, nor take longer than the fast bound
sequence relock;
	!clk_valid_ff[*8] ##[1:991] clk_valid_ff;
endsequence
need_live_a: assert property (!avs_waitrequest && avs_read && avs_address == 8'h14
	|-> avs_readdata == ($past(blk_clk_need) & `SSC_NEED_MASK)) else $error("need read");
sleep_gate_a: assert property ($rose(sys_asleep_ff) |-> $past(cpu_sleeping)
	&& ($past(blk_clk_need) & `SSC_NEED_MASK) == 0
	&& ($past(blk_sleep_cmd_ff) & `SSC_EN_ALL) == `SSC_EN_ALL) else $error("early sleep");
deep_dec_a: assert property (sleep_state_ff == 3'h3 |-> reg_standby_ff && osc_pwr_down_ff)
	else $error("deepest decode");
heavy_one_a: assert property (sleep_state_ff == 3'h0
	|-> !osc_gate_ff && !osc_pwr_down_ff && !reg_standby_ff) else $error("heavy1 decode");
gate_st_a: assert property (sleep_state_ff == 3'h1 |-> osc_gate_ff && !osc_pwr_down_ff)
	else $error("gate decode");
pd_st_a: assert property (sleep_state_ff == 3'h2 |-> osc_pwr_down_ff && !reg_standby_ff)
	else $error("osc off decode");
fast_wake_a: assert property ($fell(osc_pwr_down_ff) && wake_fast |-> relock)
	else $error("fast wake");
bad_addr_a: assert property (req && avs_waitrequest && avs_address[7:4] != 4'h1
	|=> avs_response == 2'h3) else $error("bad address");
endmodule // ssc_chk
bind ssc_sleep_ctrl ssc_chk ssc_chk_i (.*);

// [tb/ssc_periph.sv]
// Peripheral blocks and processor core beside the sleep controller.
// Bench supplies pending work and the firmware sleep request.
`timescale 1ns/1ns
module ssc_periph (
	input wire		mclk,
	input wire [31:0]	busy,
	input wire [31:0]	cmd,
	input wire		fw_sleep,
	input wire		hold,
	output reg [31:0]	need_ff,
	output wire		cpu_sleeping
);
reg [31:0] cmd_ff;
// A newly commanded block asks one more cycle to finish its work
always @(posedge mclk) begin
	cmd_ff <= cmd;
	need_ff <= busy | (cmd & ~cmd_ff);
end
assign cpu_sleeping = fw_sleep | hold;
endmodule // ssc_periph

// [tb/ssc_sleep_ctrl_tb_top.sv]
// Bench: bus, peripheral and wake stimulus checked against fixed expected values.
// Assumes one 100 MHz clock.
`timescale 1ns/1ns
`include "ssc_regs.vh"
module ssc_sleep_ctrl_tb_top;
reg mclk = 0, resetn = 0, rd = 0, wr = 0, iv = 0, ws = 0, wf = 0, fw = 0;
reg [7:0] a = 0;
reg [31:0] wd = 0, busy = 0, q, x = 32'hCDD1E3E1;
reg [1:0] rr;
wire [31:0] rq, need, cmd;
wire [1:0] rsp;
wire [2:0] st;
wire wt, cs, slp, sb, gt, pd, cv, hd;
integer mismatches = 0, n_compared = 0, cyc = 0, m, n, i;
always #5 mclk = ~mclk;
ssc_sleep_ctrl ssc_sleep_ctrl_i (.mclk(mclk), .resetn(resetn), .avs_address(a),
	.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
	.avs_readdata(rq), .avs_waitrequest(wt), .avs_response(rsp), .blk_clk_need(need),
	.cpu_sleeping(cs), .cpu_int_vector(iv), .wake_slow(ws), .wake_fast(wf),
	.blk_sleep_cmd_ff(cmd), .sys_asleep_ff(slp), .reg_standby_ff(sb), .osc_gate_ff(gt),
	.osc_pwr_down_ff(pd), .clk_valid_ff(cv), .hold_cpu_asleep_ff(hd), .sleep_state_ff(st));
ssc_periph ssc_periph_i (.mclk(mclk), .busy(busy), .cmd(cmd), .fw_sleep(fw), .hold(hd),
	.need_ff(need), .cpu_sleeping(cs));
function [31:0] xs(input [31:0] v);
	xs = v ^ (v << 13);
	xs = xs ^ (xs >> 17);
	xs = xs ^ (xs << 5);
endfunction
task chk(input [31:0] s, e);
	n_compared = n_compared + 1;
	if (s !== e) begin
		mismatches = mismatches + 1;
		$display("CHECK FAILED %0t: %h not %h", $time, s, e);
	end
endtask
task bus(input w, input [7:0] ad, input [31:0] d);
	@(posedge mclk);
	rd <= !w;
	wr <= w;
	a <= ad;
	wd <= d;
	@(posedge mclk);
	while (wt !== 1'b0) @(posedge mclk);
	q = rq;
	rr = rsp;
	rd <= 0;
	wr <= 0;
endtask
task finish_test;
	$display("compared %0d, mismatches %0d", n_compared, mismatches);
	if (mismatches == 0 && n_compared > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
// Ceiling above the 60000-cycle slow relock plus margin
always @(posedge mclk) begin
	cyc <= cyc + 1;
	if (cyc == 80000) begin
		mismatches = mismatches + 1;
		finish_test;
	end
end
initial begin
	repeat (5) @(posedge mclk);
	resetn <= 1;
	@(posedge mclk);
	chk(st, 7);
	chk(cv, 1);
	chk(wt, 1);
	bus(0, 8'h18, 0);
	chk(q, 0);
	for (i = 0; i < 4; i = i + 1) begin
		x = xs(x);
		bus(1, 8'h18, x & 32'hFFFFFFCF);
		bus(0, 8'h18, 0);
		chk(q, x & 32'h47);
	end
	busy <= x;
	bus(1, 8'h18, 0);
	bus(1, 8'h14, ~x);
	bus(0, 8'h14, 0);
	chk(q, x & `SSC_NEED_MASK);
	busy <= 0;
	bus(0, 8'h20, 0);
	chk(rr, 2'h3);
	chk(q, 0);
	$display("registers done");
	for (i = 0; i < 2; i = i + 1) begin
		bus(1, 8'h18, 32'h30 | (i << 6));
		repeat (2) @(posedge mclk);
		chk(hd, 1);
		iv <= 1;
		@(posedge mclk);
		iv <= 0;
		bus(0, 8'h18, 0);
		chk(q, i ? 32'h40 : 32'h30);
	end
	bus(1, 8'h18, 0);
	$display("auto clear done");
	// Encodings 000, 010, 001, 101; the second sleeps by enables alone
	for (i = 0; i < 4; i = i + 1) begin
		m = (16'h5120 >> (4 * i)) & 7;
		if (i == 1) bus(1, 8'h10, `SSC_EN_ALL);
		bus(1, 8'h18, m | (i == 1 ? 0 : 32'h10));
		if (i == 0) busy <= 32'h80000;
		repeat (3) @(posedge mclk);
		chk(cmd, i == 1 ? `SSC_EN_ALL : `SSC_EN_MASK);
		fw <= 1;
		repeat (10) @(posedge mclk);
		chk(slp, i != 0);
		busy <= 0;
		repeat (5) @(posedge mclk);
		chk({slp, gt, pd, sb, st}, {1'b1, m == 2, m[0], m == 5, i[2:0]});
		// The wake also ends the firmware sleep, so no instant re-entry
		if (i == 3) ws <= 1;
		else wf <= 1;
		fw <= 0;
		n = 0;
		while (cv !== 1'b1 || slp !== 1'b0) begin
			@(posedge mclk);
			n = n + 1;
		end
		chk(i == 3 ? n > 59000 && n < 61000 : n < (m[0] ? 1001 : 4), 1);
		ws <= 0;
		wf <= 0;
		bus(1, 8'h10, 0);
	end
	$display("sleep done");
	finish_test;
end
endmodule // ssc_sleep_ctrl_tb_top
